// ==== core/cca_pkg.sv ====
package cca_pkg;

    // chip address recognition, spi mode
    localparam logic [6:0] CCA_DEFAULT_CHIP = 7'h40;
    localparam logic [7:0] CCA_IND_ADDR_REG = 8'h1b;
    localparam logic [7:0] CCA_G1_ADDR_REG = 8'h1a;
    localparam logic [7:0] CCA_G2_ADDR_REG = 8'h19;
    localparam int CCA_ENABLE_BIT = 0;
    localparam int CCA_CHIP_LSB = 1;
    localparam logic [7:0] CCA_ADDR_REG_RESET = {CCA_DEFAULT_CHIP, 1'b0};

    // device register space and pointer layout
    localparam int CCA_REG_COUNT = 32;
    localparam int CCA_REG_IDX_W = 5;
    localparam int CCA_MAP_INCR_BIT = 7;
    localparam logic [2:0] CCA_LAST_BIT = 3'h7;

    // host registers on apb
    localparam logic [7:0] CCA_HOST_CMD_OFS = 8'h00;
    localparam logic [7:0] CCA_HOST_STATUS_OFS = 8'h04;
    localparam logic [7:0] CCA_HOST_CHAIN_OFS = 8'h08;
    localparam int CCA_CMD_CHIP_LSB = 0;
    localparam int CCA_CMD_RW_BIT = 7;
    localparam int CCA_CMD_MAP_LSB = 8;
    localparam int CCA_CMD_DATA_LSB = 16;
    localparam int CCA_CMD_MAP_ONLY_BIT = 24;
    localparam int CCA_STATUS_BUSY_BIT = 0;
    localparam int CCA_STATUS_RDATA_LSB = 8;
    localparam int CCA_CHAIN_REL_BIT = 0;

    // link timing: half period of the bit clock in CLOCK_IN cycles
    localparam int CCA_CLK_MHZ = 40;
    localparam int CCA_HALF_NS = 200;
    localparam int CCA_HALF_CYCLES = (CCA_HALF_NS * CCA_CLK_MHZ) / 1000;
    localparam logic [4:0] CCA_FRAME_WRITE = 5'h18;
    localparam logic [4:0] CCA_FRAME_SHORT = 5'h10;
    localparam logic [4:0] CCA_FIRST_DATA_BIT = 5'h08;

    typedef enum logic [2:0] {
        CCA_D_IDLE = 3'b000,
        CCA_D_ADDR = 3'b001,
        CCA_D_MAP = 3'b010,
        CCA_D_DATA = 3'b011,
        CCA_D_READ = 3'b100,
        CCA_D_IGNORE = 3'b101
    } cca_dev_phase_e;

    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] clk_sync;
        logic [1:0] mosi_sync;
        logic cs_prev;
        logic clk_prev;
        cca_dev_phase_e phase;
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic [7:0] map;
        logic [7:0] shift_out;
        logic miso;
        logic miso_oe_n;
        logic [CCA_REG_COUNT-1:0][7:0] regs;
    } cca_dev_s;

    typedef enum logic [1:0] {
        CCA_H_IDLE = 2'b00,
        CCA_H_SHIFT = 2'b01,
        CCA_H_END = 2'b10,
        CCA_H_GAP = 2'b11
    } cca_host_phase_e;

    typedef struct packed {
        cca_host_phase_e phase;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [4:0] bit_cnt;
        logic [4:0] nbits;
        logic rd;
        logic [23:0] shift;
        logic [7:0] rdata;
        logic [1:0] miso_sync;
        logic chain_rel;
        logic [31:0] prdata;
    } cca_host_s;

endpackage

// ==== core/cca_link_if.sv ====
`timescale 1ns/1ps
interface cca_link_if;
    // bit clock, select and data run in parallel to every device
    logic control_bit_clock;
    logic cs_n;
    logic mosi;
    // read data pin: driven by a device only while its enable is low
    logic miso_drv;
    logic miso_oe_n;
    logic miso_line;
    // reset of the first device in the chain
    logic chain_rst_n;

    // undriven line floats high as through a pull-up
    assign miso_line = miso_oe_n ? 1'b1 : miso_drv;

    modport dev (
        input control_bit_clock,
        input cs_n,
        input mosi,
        output miso_drv,
        output miso_oe_n
    );

    modport host (
        output control_bit_clock,
        output cs_n,
        output mosi,
        output chain_rst_n,
        input miso_line
    );
endinterface

// ==== core/cca_chain_dev.sv ====
`timescale 1ns/1ps
module cca_chain_dev
    import cca_pkg::*;
(
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // serial control link
    cca_link_if.dev link,
    // chain and status
    output logic NEXT_DEVICE_RELEASE_OUT,
    output logic [6:0] INDIVIDUAL_ADDR_OUT
);

    cca_dev_s st_ff;
    cca_dev_s nxt_st;

    // true when a received chip field selects this address register;
    // groups need their enable bit, the individual address never does
    function automatic logic chip_hit(input logic [6:0] chip, input logic [7:0] areg,
                                      input logic need_en);
        chip_hit = (chip == areg[7:CCA_CHIP_LSB]) && (!need_en || areg[CCA_ENABLE_BIT]);
    endfunction

    // pointer inside the implemented register space;
    // pointers beyond it write nowhere and read as zero
    function automatic logic map_ok(input logic [7:0] m);
        map_ok = m[6:0] < 7'(CCA_REG_COUNT);
    endfunction

    // pointer advance when the increment flag is set
    function automatic logic [7:0] map_step(input logic [7:0] m);
        map_step = m[CCA_MAP_INCR_BIT] ? {m[7], m[6:0] + 7'h01} : m;
    endfunction

    logic clk_s;
    logic cs_s;
    logic mosi_s;
    logic clk_rise;
    logic clk_fall;
    logic frame_start;
    logic [7:0] rx_byte;
    logic [6:0] rx_chip;
    logic [7:0] rd_val;
    logic [7:0] step_map;
    logic [7:0] ind_reg;
    logic [7:0] g1_reg;
    logic [7:0] g2_reg;
    logic ind_hit;
    logic grp_hit;

    // synchronised pin levels, second flop only
    assign clk_s = st_ff.clk_sync[1];
    assign cs_s = st_ff.cs_sync[1];
    assign mosi_s = st_ff.mosi_sync[1];

    // edges of the bit clock and select, found against last cycle's level;
    // clk_prev resets to the idle low level so reset brings no false edge
    assign clk_rise = clk_s && !st_ff.clk_prev;
    assign clk_fall = !clk_s && st_ff.clk_prev;
    assign frame_start = !cs_s && st_ff.cs_prev;

    // byte as it stands after this bit, and its chip field
    assign rx_byte = {st_ff.shift_in[6:0], mosi_s};
    assign rx_chip = rx_byte[7:1];
    assign step_map = map_step(st_ff.map);

    // the three address registers, read by matching; the individual one also by the pins
    assign ind_reg = st_ff.regs[CCA_IND_ADDR_REG[CCA_REG_IDX_W-1:0]];
    assign g1_reg = st_ff.regs[CCA_G1_ADDR_REG[CCA_REG_IDX_W-1:0]];
    assign g2_reg = st_ff.regs[CCA_G2_ADDR_REG[CCA_REG_IDX_W-1:0]];

    // matching always uses current register contents
    // configured devices answer their individual address
    assign ind_hit = chip_hit(rx_chip, ind_reg, 1'b0);
    assign grp_hit = chip_hit(rx_chip, g1_reg, 1'b1) || chip_hit(rx_chip, g2_reg, 1'b1);

    // read data for the pointer that a read continues with
    always_comb begin
        logic [7:0] m;
        m = (st_ff.phase == CCA_D_READ) ? step_map : st_ff.map;
        rd_val = map_ok(m) ? st_ff.regs[m[CCA_REG_IDX_W-1:0]] : 8'h00;
    end

    // frame decoder and register writes
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cs_sync = {st_ff.cs_sync[0], link.cs_n};
        nxt_st.clk_sync = {st_ff.clk_sync[0], link.control_bit_clock};
        nxt_st.mosi_sync = {st_ff.mosi_sync[0], link.mosi};
        nxt_st.cs_prev = cs_s;
        nxt_st.clk_prev = clk_s;
        if (cs_s) begin
            // select high ends any frame, ignored or not
            nxt_st.phase = CCA_D_IDLE;
            nxt_st.miso_oe_n = 1'b1;
        end else if (frame_start) begin
            nxt_st.phase = CCA_D_ADDR;
            nxt_st.bit_cnt = 3'h0;
        end else if (clk_rise) begin
            // bits taken on rising bit clock edges
            nxt_st.shift_in = rx_byte;
            nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
            if (st_ff.bit_cnt == CCA_LAST_BIT) begin
                unique case (st_ff.phase)
                    CCA_D_ADDR: begin
                        if (rx_byte[0]) begin
                            // reads only through the individual address
                            // group reads fall to ignore, pin stays released
                            if (ind_hit) begin
                                nxt_st.phase = CCA_D_READ;
                                nxt_st.shift_out = rd_val;
                            end else begin
                                nxt_st.phase = CCA_D_IGNORE;
                            end
                        end else begin
                            nxt_st.phase = (ind_hit || grp_hit) ? CCA_D_MAP : CCA_D_IGNORE;
                        end
                    end
                    CCA_D_MAP: begin
                        nxt_st.map = rx_byte;
                        nxt_st.phase = CCA_D_DATA;
                    end
                    CCA_D_DATA: begin
                        // whole byte stored, address and enable together
                        if (map_ok(st_ff.map)) begin
                            nxt_st.regs[st_ff.map[CCA_REG_IDX_W-1:0]] = rx_byte;
                        end
                        nxt_st.map = step_map;
                    end
                    CCA_D_READ: begin
                        nxt_st.map = step_map;
                        nxt_st.shift_out = rd_val;
                    end
                    CCA_D_IDLE, CCA_D_IGNORE: begin
                        nxt_st.phase = st_ff.phase;
                    end
                    default: begin
                        nxt_st.phase = CCA_D_IGNORE;
                    end
                endcase
            end
        end else if (clk_fall && st_ff.phase == CCA_D_READ) begin
            // read bits leave on the falling edge, msb first
            // host samples at its next rise, half a bit period on; sync delay fits
            nxt_st.miso = st_ff.shift_out[7];
            nxt_st.shift_out = {st_ff.shift_out[6:0], 1'b0};
            nxt_st.miso_oe_n = 1'b0;
        end
    end

    // state register; select idles high and clock low after reset
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_ff <= '0;
            // a device released mid-frame sees select fall as a frame start, so it decodes a half frame
            st_ff.cs_sync <= 2'b11;
            st_ff.cs_prev <= 1'b1;
            st_ff.miso_oe_n <= 1'b1;
            st_ff.phase <= CCA_D_IDLE;
            // default address in all three registers
            st_ff.regs[CCA_IND_ADDR_REG[4:0]] <= CCA_ADDR_REG_RESET;
            st_ff.regs[CCA_G1_ADDR_REG[4:0]] <= CCA_ADDR_REG_RESET;
            st_ff.regs[CCA_G2_ADDR_REG[4:0]] <= CCA_ADDR_REG_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // address registers live at their pointer values
    assign INDIVIDUAL_ADDR_OUT = ind_reg[7:CCA_CHIP_LSB];

    // flop is cleared asynchronously by reset
    // release follows the next-device enable bit
    // this output feeds the next device reset
    assign NEXT_DEVICE_RELEASE_OUT = ind_reg[CCA_ENABLE_BIT];

    // read data pin, released outside read frames
    // the pull-up on the shared line gives a reader ones when nobody answers
    assign link.miso_drv = st_ff.miso;
    assign link.miso_oe_n = st_ff.miso_oe_n;

endmodule

// ==== core/cca_chain_host.sv ====
`timescale 1ns/1ps
module cca_chain_host
    import cca_pkg::*;
#(
    parameter int HALF_CYCLES = CCA_HALF_CYCLES
) (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // serial control link
    cca_link_if.host link
);

    cca_host_s st_ff;
    cca_host_s nxt_st;
    logic tick;
    logic busy;
    logic mapped;

    assign busy = st_ff.phase != CCA_H_IDLE;
    // divider gives one enable per half bit period
    assign tick = st_ff.div == 8'(HALF_CYCLES - 1);
    assign mapped = PADDR_IN == CCA_HOST_CMD_OFS || PADDR_IN == CCA_HOST_STATUS_OFS
                 || PADDR_IN == CCA_HOST_CHAIN_OFS;

    // apb decode and frame sequencer
    always_comb begin
        nxt_st = st_ff;
        nxt_st.miso_sync = {st_ff.miso_sync[0], link.miso_line};
        // read data registered in the setup cycle, shown in access
        if (PSEL_IN && !PENABLE_IN) begin
            unique case (PADDR_IN)
                CCA_HOST_STATUS_OFS: nxt_st.prdata = {16'h0000, st_ff.rdata, 7'h00, busy};
                CCA_HOST_CHAIN_OFS: nxt_st.prdata = {31'h00000000, st_ff.chain_rel};
                default: nxt_st.prdata = 32'h00000000;
            endcase
        end
        if (busy) begin
            nxt_st.div = tick ? 8'h00 : st_ff.div + 8'h01;
        end
        unique case (st_ff.phase)
            CCA_H_IDLE: begin
                // a command is taken only while idle
                if (PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == CCA_HOST_CMD_OFS) begin
                    // chip and rw byte first, then pointer, then data, msb first
                    nxt_st.shift = {PWDATA_IN[CCA_CMD_CHIP_LSB +: 7], PWDATA_IN[CCA_CMD_RW_BIT],
                        PWDATA_IN[CCA_CMD_MAP_LSB +: 8], PWDATA_IN[CCA_CMD_DATA_LSB +: 8]};
                    nxt_st.rd = PWDATA_IN[CCA_CMD_RW_BIT];
                    nxt_st.nbits = (PWDATA_IN[CCA_CMD_RW_BIT] || PWDATA_IN[CCA_CMD_MAP_ONLY_BIT])
                                 ? CCA_FRAME_SHORT : CCA_FRAME_WRITE;
                    nxt_st.cs_n = 1'b0;
                    nxt_st.mosi = PWDATA_IN[CCA_CMD_CHIP_LSB + 6];
                    nxt_st.sclk = 1'b0;
                    nxt_st.div = 8'h00;
                    nxt_st.bit_cnt = 5'h00;
                    nxt_st.phase = CCA_H_SHIFT;
                end
            end
            CCA_H_SHIFT: begin
                if (tick && !st_ff.sclk) begin
                    nxt_st.sclk = 1'b1;
                    // read bits sampled at our own rising edge
                    if (st_ff.rd && st_ff.bit_cnt >= CCA_FIRST_DATA_BIT) begin
                        nxt_st.rdata = {st_ff.rdata[6:0], st_ff.miso_sync[1]};
                    end
                end else if (tick) begin
                    nxt_st.sclk = 1'b0;
                    nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                    if (st_ff.bit_cnt == st_ff.nbits - 5'h01) begin
                        nxt_st.phase = CCA_H_END;
                    end else begin
                        nxt_st.shift = {st_ff.shift[22:0], 1'b0};
                        nxt_st.mosi = st_ff.shift[22];
                    end
                end
            end
            CCA_H_END: begin
                if (tick) begin
                    nxt_st.cs_n = 1'b1;
                    nxt_st.phase = CCA_H_GAP;
                end
            end
            CCA_H_GAP: begin
                // select stays high a half period between frames
                if (tick) begin
                    nxt_st.phase = CCA_H_IDLE;
                end
            end
        endcase
        // the chain reset is the only per-device line
        if (PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == CCA_HOST_CHAIN_OFS) begin
            nxt_st.chain_rel = PWDATA_IN[CCA_CHAIN_REL_BIT];
        end
    end

    // state register
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_ff <= '0;
            st_ff.cs_n <= 1'b1;
            st_ff.miso_sync <= 2'b11;
            st_ff.phase <= CCA_H_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // apb answers with no wait states
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
    assign PRDATA_OUT = st_ff.prdata;

    // link pins
    assign link.control_bit_clock = st_ff.sclk;
    assign link.cs_n = st_ff.cs_n;
    assign link.mosi = st_ff.mosi;
    // first device held in reset until software releases it
    assign link.chain_rst_n = st_ff.chain_rel;

endmodule

// ==== tb/cca_link_checker.sv ====
`timescale 1ns/1ps
module cca_link_checker (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // shared link lines
    input wire logic control_bit_clock,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_oe_n,
    input wire logic chain_rst_n,
    // release of the first device
    input wire logic NEXT_DEVICE_RELEASE_OUT
);
    logic [5:0] nbits_ff;

    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    // counts bit clock rises inside one select window
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            nbits_ff <= 6'h00;
        end else if (cs_n) begin
            nbits_ff <= 6'h00;
        end else if ($rose(control_bit_clock)) begin
            nbits_ff <= nbits_ff + 6'h01;
        end
    end

    // framing of the bit clock and data line
    chk_idle_clock_low: assert property (
        cs_n |-> !control_bit_clock) else $error("bit clock high outside a frame");
    chk_mosi_held_high: assert property (
        control_bit_clock && $past(control_bit_clock) |-> $stable(mosi))
        else $error("data changed while bit clock high");
    chk_sclk_half_period: assert property (
        $rose(control_bit_clock) |-> control_bit_clock [*8] ##1 !control_bit_clock)
        else $error("bit clock high time wrong");
    chk_frame_bit_count: assert property (
        $rose(cs_n) |-> (nbits_ff == 6'h10) || (nbits_ff == 6'h18))
        else $error("frame length wrong");
    // read data pin ownership
    chk_oe_released: assert property (
        $rose(cs_n) |-> ##[0:6] miso_oe_n) else $error("read pin kept after frame");
    chk_oe_start: assert property (
        $fell(miso_oe_n) |-> !cs_n && !control_bit_clock)
        else $error("read pin taken at wrong moment");
    chk_reset_quiet: assert property (
        !chain_rst_n |-> miso_oe_n) else $error("read pin driven in reset");
    // chain release output
    chk_release_low: assert property (
        !chain_rst_n |-> !NEXT_DEVICE_RELEASE_OUT) else $error("release high in reset");
    chk_release_rise: assert property (
        $rose(NEXT_DEVICE_RELEASE_OUT) |-> !cs_n && chain_rst_n)
        else $error("release rose outside a write");
    chk_release_fall: assert property (
        $fell(NEXT_DEVICE_RELEASE_OUT) |-> !cs_n || !chain_rst_n)
        else $error("release fell without cause");

    // main scenarios reached
    cover property ($fell(miso_oe_n));
    cover property ($rose(NEXT_DEVICE_RELEASE_OUT));
    cover property ($rose(cs_n) && nbits_ff == 6'h10);
    cover property ($rose(cs_n) && nbits_ff == 6'h18);
endmodule

// ==== tb/chained_chip_address_config_tb.sv ====
`timescale 1ns/1ps
module chained_chip_address_config_tb
    import cca_pkg::*;
;
    typedef struct packed {logic [1:0] id; logic [7:0] exp;} cca_note_s;
    logic CLOCK_IN, RST_N_IN, psel, pen, pwr, pready, pslverr, pslv_q, chk_req, rel0, rel1;
    logic [7:0] paddr, ga, v, old, got;
    logic [31:0] pwdata, prdata, rd_q;
    logic [6:0] ia0, ia1, gc;
    int errors, comparisons;
    cca_note_s notes[$];
    cca_note_s nt;
    string nm[4] = '{"dev0", "dev1", "rdata", "slverr"};

    cca_link_if link_a();
    cca_link_if link_b();
    // only the reset line is chained; clock, select and data run in parallel
    assign link_b.control_bit_clock = link_a.control_bit_clock;
    assign link_b.cs_n = link_a.cs_n;
    assign link_b.mosi = link_a.mosi;
    // release of the first device is the reset of the second
    assign link_b.chain_rst_n = rel0;

    cca_chain_host i_cca_chain_host (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .link(link_a));
    cca_chain_dev i_cca_chain_dev_0 (.CLOCK_IN(CLOCK_IN), .RST_N_IN(link_a.chain_rst_n),
        .link(link_a), .NEXT_DEVICE_RELEASE_OUT(rel0), .INDIVIDUAL_ADDR_OUT(ia0));
    // second device is checked only at its pins, never read over the link, so its read pin stays local
    cca_chain_dev i_cca_chain_dev_1 (.CLOCK_IN(CLOCK_IN), .RST_N_IN(rel0),
        .link(link_b), .NEXT_DEVICE_RELEASE_OUT(rel1), .INDIVIDUAL_ADDR_OUT(ia1));
    cca_link_checker i_cca_link_checker (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
        .control_bit_clock(link_a.control_bit_clock), .cs_n(link_a.cs_n),
        .mosi(link_a.mosi), .miso_oe_n(link_a.miso_oe_n),
        .chain_rst_n(link_a.chain_rst_n), .NEXT_DEVICE_RELEASE_OUT(rel0));

    // free running clock
    initial begin
        CLOCK_IN = 1'b0;
        forever #12.5 CLOCK_IN = ~CLOCK_IN;
    end

    task automatic end_of_test();
        @(posedge CLOCK_IN);
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        errors++;
        end_of_test();
    endtask

    // one apb transfer, waits a bounded time for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge CLOCK_IN);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLOCK_IN);
        pen <= 1'b1;
        do begin
            @(posedge CLOCK_IN);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) timed_out();
        rd_q = prdata;
        pslv_q = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // issue one link frame and poll until the host is idle again
    task automatic frame(input logic [6:0] c, input logic rw, input logic [7:0] m,
                         input logic [7:0] d, input logic mo);
        int n = 0;
        apb(1'b1, CCA_HOST_CMD_OFS, {7'h00, mo, d, m, rw, c});
        repeat (4) @(posedge CLOCK_IN);
        do begin
            apb(1'b0, CCA_HOST_STATUS_OFS, 32'h0);
            n++;
        end while (rd_q[CCA_STATUS_BUSY_BIT] !== 1'b0 && n < 2000);
        if (rd_q[CCA_STATUS_BUSY_BIT] !== 1'b0) timed_out();
    endtask

    // pointer frame first, since a read cannot set the pointer
    task automatic rdreg(input logic [6:0] c, input logic [7:0] m);
        frame(c, 1'b0, m, 8'h00, 1'b1);
        frame(c, 1'b1, 8'h00, 8'h00, 1'b0);
    endtask

    // the driver only notes what it expects; the monitor compares
    task automatic note(input logic [1:0] id, input logic [7:0] e);
        @(posedge CLOCK_IN);
        notes.push_back('{id, e});
        chk_req <= 1'b1;
        @(posedge CLOCK_IN);
        chk_req <= 1'b0;
    endtask

    // monitor takes the oldest note whenever a result is flagged
    always @(posedge CLOCK_IN) begin
        if (chk_req === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            case (nt.id)
                2'h0: got = {rel0, ia0};
                2'h1: got = {rel1, ia1};
                2'h2: got = rd_q[15:8];
                default: got = {7'h00, pslv_q};
            endcase
            comparisons++;
            if (got !== nt.exp) begin
                errors++;
                $display("mismatch %s expected %h seen %h", nm[nt.id], nt.exp, got);
            end
        end
    end

    // main sequence
    initial begin
        {psel, pen, pwr, chk_req, RST_N_IN} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        comparisons = 0;
        old = 8'h00;
        void'($urandom(11970));
        repeat (8) @(posedge CLOCK_IN);
        RST_N_IN <= 1'b1;
        note(2'h0, {1'b0, CCA_DEFAULT_CHIP});
        note(2'h1, {1'b0, CCA_DEFAULT_CHIP});
        apb(1'b0, 8'h0c, 32'h0);
        note(2'h3, 8'h01);
        note(2'h2, 8'h00);
        apb(1'b1, CCA_HOST_CHAIN_OFS, 32'h1);
        frame(CCA_DEFAULT_CHIP, 1'b0, CCA_IND_ADDR_REG, {7'h11, 1'b1}, 1'b0);
        note(2'h0, {1'b1, 7'h11});
        note(2'h1, {1'b0, CCA_DEFAULT_CHIP});
        frame(CCA_DEFAULT_CHIP, 1'b0, CCA_IND_ADDR_REG, {7'h22, 1'b0}, 1'b0);
        note(2'h0, {1'b1, 7'h11});
        note(2'h1, {1'b0, 7'h22});
        frame(7'h22, 1'b0, CCA_IND_ADDR_REG, {7'h22, 1'b1}, 1'b0);
        note(2'h1, {1'b1, 7'h22});
        rdreg(7'h11, CCA_IND_ADDR_REG);
        note(2'h2, {7'h11, 1'b1});
        for (int g = 0; g < 2; g++) begin
            ga = (g == 0) ? CCA_G1_ADDR_REG : CCA_G2_ADDR_REG;
            gc = 7'h30 + 7'(g);
            v = 8'($urandom) | 8'h01;
            // a value equal to the old one could not show an ignored write
            if (v == old) begin
                v = v ^ 8'h02;
            end
            frame(7'h11, 1'b0, ga, {gc, 1'b0}, 1'b0);
            frame(gc, 1'b0, 8'h03, v, 1'b0);
            rdreg(7'h11, 8'h03);
            note(2'h2, old);
            frame(7'h11, 1'b0, ga, {gc, 1'b1}, 1'b0);
            frame(7'h22, 1'b0, ga, {gc, 1'b1}, 1'b0);
            frame(gc, 1'b0, 8'h03, v, 1'b0);
            rdreg(7'h11, 8'h03);
            note(2'h2, v);
            old = v;
            rdreg(7'h11, ga);
            note(2'h2, {gc, 1'b1});
            frame(gc, 1'b1, 8'h00, 8'h00, 1'b0);
            note(2'h2, 8'hff);
        end
        apb(1'b1, CCA_HOST_CHAIN_OFS, 32'h0);
        note(2'h0, {1'b0, CCA_DEFAULT_CHIP});
        note(2'h1, {1'b0, CCA_DEFAULT_CHIP});
        apb(1'b1, CCA_HOST_CHAIN_OFS, 32'h1);
        rdreg(CCA_DEFAULT_CHIP, CCA_G1_ADDR_REG);
        note(2'h2, CCA_ADDR_REG_RESET);
        end_of_test();
    end
endmodule
